// *** iocdm_defines.svh ***
// Constants for the I/O channel diagnostic monitor
`ifndef IOCDM_DEFINES_SVH
`define IOCDM_DEFINES_SVH

`define IOCDM_N_DIG      8
`define IOCDM_N_AI       4
`define IOCDM_CNT_W      27
`define IOCDM_THR_MAX    16'hfde8
`define IOCDM_CNT_SCALE  27'h00003e8
`define IOCDM_CNT_SAT    27'h7ffffff
`define IOCDM_HOUR_S     64'h0000000000000e10
`define IOCDM_CLK_HZ     64'h0000000002625a00
// Span bounds and 0.5% margins in hundredths, range 7 first
`define IOCDM_RANGE_LO   {16'h0190, 16'h0000, 16'h0064, 16'h0000, \
                          16'h0000, 16'hf830, 16'hfe0c, 16'hfc18}
`define IOCDM_RANGE_HI   {16'h07d0, 16'h07d0, 16'h01f4, 16'h01f4, \
                          16'h03e8, 16'h07d0, 16'h01f4, 16'h03e8}
`define IOCDM_RANGE_M    {16'h0008, 16'h000a, 16'h0002, 16'h0002, \
                          16'h0005, 16'h0014, 16'h0005, 16'h000a}

`endif

// *** iocdm_pkg.sv ***
// Types for the I/O channel diagnostic monitor
package iocdm_pkg;
    typedef enum logic [2:0] {
        IOCDM_RNG_BI10V  = 3'h0,
        IOCDM_RNG_BI5V   = 3'h1,
        IOCDM_RNG_BI20MA = 3'h2,
        IOCDM_RNG_U10V   = 3'h3,
        IOCDM_RNG_U5V    = 3'h4,
        IOCDM_RNG_U1_5V  = 3'h5,
        IOCDM_RNG_U20MA  = 3'h6,
        IOCDM_RNG_U4_20MA = 3'h7
    } iocdm_range_t;

    typedef enum logic [1:0] {
        IOCDM_AVG_NONE          = 2'h0,
        IOCDM_AVG_TWO_SAMPLES   = 2'h1,
        IOCDM_AVG_FOUR_SAMPLES  = 2'h2,
        IOCDM_AVG_EIGHT_SAMPLES = 2'h3
    } iocdm_avg_t;

    typedef enum logic [1:0] {
        IOCDM_FMT_OFFSET = 2'h0,
        IOCDM_FMT_SIGN_MAG = 2'h1,
        IOCDM_FMT_TWOS   = 2'h2
    } iocdm_fmt_t;

    typedef enum logic [1:0] {
        IOCDM_ST_RESTORE = 2'h0,
        IOCDM_ST_RUN     = 2'h1,
        IOCDM_ST_SAVE    = 2'h3
    } iocdm_state_t;
endpackage

// *** iocdm_retain_mem.sv ***
// Retained storage for the operation counts
`timescale 1ns/100ps
module iocdm_retain_mem (
    input  wire logic        i_clk,
    // Write port
    input  wire logic        i_we,
    input  wire logic [2:0]  i_waddr,
    input  wire logic [26:0] i_wdata,
    // Read port
    input  wire logic [2:0]  i_raddr,
    output logic      [26:0] o_rdata
);
    logic [26:0] mem_r [0:7];

    // No reset: contents survive a reset of the logic
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_r[i_raddr];
    end
endmodule

// *** iocdm_top.sv ***
// Channel monitor: operation counters and analogue input diagnostics
`timescale 1ns/100ps
`include "iocdm_defines.svh"
module iocdm_top #(
    parameter logic [63:0] HOUR_CYCLES = `IOCDM_HOUR_S * `IOCDM_CLK_HZ
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Digital channels
    input  wire logic [7:0]   i_dig_in,
    input  wire logic [7:0]   i_cnt_err_en,
    input  wire logic [127:0] i_cnt_thr,
    input  wire logic [7:0]   i_cnt_clr,
    output logic      [7:0]   o_cnt_err,
    output logic      [215:0] o_cnt_value,
    output logic              o_restore_done,
    // Supply short detection
    input  wire logic         i_sup_short,
    input  wire logic         i_sup_det_en,
    output logic              o_sup_err,
    // Analogue channels
    input  wire logic [63:0]  i_ai_sample,
    input  wire logic [3:0]   i_ai_valid,
    input  wire logic [11:0]  i_ai_range,
    input  wire logic [7:0]   i_avg_mode,
    input  wire logic [1:0]   i_fmt,
    input  wire logic         i_over_en,
    input  wire logic         i_under_en,
    input  wire logic [3:0]   i_ulim_hi_en,
    input  wire logic [3:0]   i_ulim_lo_en,
    input  wire logic [63:0]  i_ulim_hi,
    input  wire logic [63:0]  i_ulim_lo,
    output logic      [63:0]  o_ai_data,
    output logic      [3:0]   o_ai_upd,
    output logic      [3:0]   o_over_err,
    output logic      [3:0]   o_under_err,
    output logic      [3:0]   o_ulim_hi_err,
    output logic      [3:0]   o_ulim_lo_err
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    localparam logic [127:0] RLO = `IOCDM_RANGE_LO;
    localparam logic [127:0] RHI = `IOCDM_RANGE_HI;
    localparam logic [127:0] RM  = `IOCDM_RANGE_M;

    iocdm_pkg::iocdm_state_t state_r, state_nxt;
    logic [3:0]  idx_r;
    logic [63:0] hour_r;
    logic [7:0]  dig_s1_r, dig_s2_r, dig_q_r;
    logic        sup_s1_r, sup_s2_r;
    logic        rd_vld_r;
    logic [2:0]  rd_idx_r;
    logic [26:0] rdata;
    logic [26:0] cnt_r [0:7];

    wire hour_tick = (hour_r == HOUR_CYCLES - 64'h1);
    wire in_run    = (state_r == iocdm_pkg::IOCDM_ST_RUN);
    wire in_save   = (state_r == iocdm_pkg::IOCDM_ST_SAVE);
    wire in_rest   = (state_r == iocdm_pkg::IOCDM_ST_RESTORE);
    wire last_save = (idx_r == 4'h7);
    wire rest_end  = (idx_r == 4'h8);

    // Sequencer: restore after reset, hourly save
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            iocdm_pkg::IOCDM_ST_RESTORE: begin
                if (rest_end) state_nxt = iocdm_pkg::IOCDM_ST_RUN;
            end
            iocdm_pkg::IOCDM_ST_RUN: begin
                if (hour_tick) state_nxt = iocdm_pkg::IOCDM_ST_SAVE;
            end
            iocdm_pkg::IOCDM_ST_SAVE: begin
                if (last_save) state_nxt = iocdm_pkg::IOCDM_ST_RUN;
            end
            default: state_nxt = iocdm_pkg::IOCDM_ST_RESTORE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= iocdm_pkg::IOCDM_ST_RESTORE;
            idx_r   <= 4'h0;
            hour_r  <= 64'h0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= (state_nxt != state_r) ? 4'h0 : idx_r + 4'h1;
            hour_r  <= (hour_tick || in_rest) ? 64'h0 : hour_r + 64'h1;
        end
    end

    // Read-back pipeline for restore
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_vld_r       <= 1'b0;
            rd_idx_r       <= 3'h0;
            o_restore_done <= 1'b0;
        end else begin
            rd_vld_r       <= in_rest && !idx_r[3];
            rd_idx_r       <= idx_r[2:0];
            o_restore_done <= !in_rest;
        end
    end

    iocdm_retain_mem u_iocdm_retain_mem (
        .i_clk   (i_clk),
        .i_we    (in_save),
        .i_waddr (idx_r[2:0]),
        .i_wdata (cnt_r[idx_r[2:0]]),
        .i_raddr (idx_r[2:0]),
        .o_rdata (rdata)
    );

    // Pin synchronisers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            dig_s1_r  <= 8'h00;
            dig_s2_r  <= 8'h00;
            dig_q_r   <= 8'h00;
            sup_s1_r  <= 1'b0;
            sup_s2_r  <= 1'b0;
            o_sup_err <= 1'b0;
        end else begin
            dig_s1_r  <= i_dig_in;
            dig_s2_r  <= dig_s1_r;
            dig_q_r   <= dig_s2_r;
            sup_s1_r  <= i_sup_short;
            sup_s2_r  <= sup_s1_r;
            o_sup_err <= i_sup_det_en && sup_s2_r;
        end
    end

    sup_off_a: assert property (!i_sup_det_en |=> !o_sup_err)
        else $error("supply error raised while detection disabled");

    genvar g;
    for (g = 0; g < `IOCDM_N_DIG; g = g + 1) begin : g_dig
        wire [15:0] thr_w = i_cnt_thr[g*16 +: 16];
        wire [15:0] thr_c = (thr_w > `IOCDM_THR_MAX) ? `IOCDM_THR_MAX : thr_w;
        wire [26:0] lim   = {11'h000, thr_c} * `IOCDM_CNT_SCALE;
        wire        rise  = dig_s2_r[g] && !dig_q_r[g];
        wire        load  = rd_vld_r && (rd_idx_r == 3'(g));
        wire        sat   = (cnt_r[g] == `IOCDM_CNT_SAT);
        wire [26:0] cnt_nxt = i_cnt_clr[g] ? 27'h0 :
                              load ? rdata :
                              (rise && !sat && !in_rest) ? cnt_r[g] + 27'h1 : cnt_r[g];

        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                cnt_r[g]     <= 27'h0;
                o_cnt_err[g] <= 1'b0;
            end else begin
                cnt_r[g]     <= cnt_nxt;
                o_cnt_err[g] <= i_cnt_err_en[g] && (cnt_r[g] > lim);
            end
        end
        assign o_cnt_value[g*27 +: 27] = cnt_r[g];

        cnt_err_a: assert property (o_cnt_err[g] ==
                $past(i_cnt_err_en[g] && (cnt_r[g] > {11'h000, thr_c} * 27'h00003e8)))
            else $error("counter error does not follow count and threshold");
        cnt_clr_a: assert property (i_cnt_clr[g] |=> cnt_r[g] == 27'h0)
            else $error("counter not zero after clear");
    end

    save_seq_a: assert property (in_run && hour_tick |=> in_save [*8] ##1 in_run)
        else $error("hourly save did not cover all channels");
    restore_a: assert property ($rose(i_rst_n) |-> ##[1:12] in_run)
        else $error("restore did not finish in time");
    save_c: cover property (in_save ##1 in_run);
    clr_c:  cover property (i_cnt_clr[0] && o_cnt_err[0]);

    for (g = 0; g < `IOCDM_N_AI; g = g + 1) begin : g_ai
        logic [15:0] h_r [0:7];
        logic        upd_r;
        wire  [2:0]  rng = i_ai_range[g*3 +: 3];
        wire  [1:0]  am  = i_avg_mode[g*2 +: 2];
        wire  [18:0] s2 = {{3{h_r[0][15]}}, h_r[0]} + {{3{h_r[1][15]}}, h_r[1]};
        wire  [18:0] s4 = s2 + {{3{h_r[2][15]}}, h_r[2]} + {{3{h_r[3][15]}}, h_r[3]};
        wire  [18:0] s8 = s4 + {{3{h_r[4][15]}}, h_r[4]} + {{3{h_r[5][15]}}, h_r[5]}
                             + {{3{h_r[6][15]}}, h_r[6]} + {{3{h_r[7][15]}}, h_r[7]};
        wire  [15:0] avg = (am == iocdm_pkg::IOCDM_AVG_TWO_SAMPLES)   ? s2[16:1] :
                           (am == iocdm_pkg::IOCDM_AVG_FOUR_SAMPLES)  ? s4[17:2] :
                           (am == iocdm_pkg::IOCDM_AVG_EIGHT_SAMPLES) ? s8[18:3] : h_r[0];
        wire  signed [16:0] v    = $signed({avg[15], avg});
        wire  [15:0] lo_w = RLO[rng*16 +: 16];
        wire  [15:0] hi_w = RHI[rng*16 +: 16];
        wire  [15:0] m_w  = RM[rng*16 +: 16];
        wire  signed [16:0] top  = $signed({hi_w[15], hi_w}) + $signed({1'b0, m_w});
        wire  signed [16:0] bot  = $signed({lo_w[15], lo_w}) - $signed({1'b0, m_w});
        wire  [15:0] uh = i_ulim_hi[g*16 +: 16];
        wire  [15:0] ul = i_ulim_lo[g*16 +: 16];
        wire  [15:0] mag = 16'h0 - avg;
        wire  [15:0] fmt = (i_fmt == iocdm_pkg::IOCDM_FMT_OFFSET) ? {~avg[15], avg[14:0]} :
                           (i_fmt == iocdm_pkg::IOCDM_FMT_SIGN_MAG && avg[15]) ?
                           {1'b1, mag[14:0]} : avg;

        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                for (int k = 0; k < 8; k = k + 1) begin
                    h_r[k] <= 16'h0000;
                end
                upd_r <= 1'b0;
            end else begin
                upd_r <= i_ai_valid[g];
                if (i_ai_valid[g]) begin
                    h_r[0] <= i_ai_sample[g*16 +: 16];
                    for (int k = 1; k < 8; k = k + 1) begin
                        h_r[k] <= h_r[k-1];
                    end
                end
            end
        end

        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                o_ai_data[g*16 +: 16] <= 16'h0000;
                o_ai_upd[g]      <= 1'b0;
                o_over_err[g]    <= 1'b0;
                o_under_err[g]   <= 1'b0;
                o_ulim_hi_err[g] <= 1'b0;
                o_ulim_lo_err[g] <= 1'b0;
            end else begin
                o_ai_upd[g] <= upd_r;
                if (upd_r) begin
                    o_ai_data[g*16 +: 16] <= fmt;
                    o_over_err[g]    <= i_over_en && (v > top);
                    o_under_err[g]   <= i_under_en && (v < bot);
                    o_ulim_hi_err[g] <= i_ulim_hi_en[g] && ($signed(avg) > $signed(uh));
                    o_ulim_lo_err[g] <= i_ulim_lo_en[g] && ($signed(avg) < $signed(ul));
                end
            end
        end

        over_off_a: assert property (upd_r && !i_over_en |=> !o_over_err[g])
            else $error("over range error while detection disabled");
        ulim_hi_a: assert property (upd_r && i_ulim_hi_en[g] &&
                ($signed(avg) > $signed(uh)) |=> o_ulim_hi_err[g] && o_ai_upd[g])
            else $error("upper limit error missing");
        fmt_off_a: assert property (upd_r && i_fmt == 2'h0 |=>
                o_ai_data[g*16 + 15] != $past(avg[15]))
            else $error("offset binary sign bit wrong");
        over_c: cover property (o_over_err[g] ##1 !o_over_err[g]);
    end
endmodule

// *** iocdm_field_model.sv ***
// Field-side model: pulses the digital channel pins on request
`timescale 1ns/100ps
module iocdm_field_model (
    // Clock and request
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic [15:0] i_n_pulses,
    // Pins and status
    output logic      [7:0]  o_dig,
    output logic             o_busy
);
    logic [16:0] left_r;
    initial begin
        o_dig = 8'h00;
        left_r = 17'h00000;
    end
    assign o_busy = (left_r != 17'h00000);
    // High one cycle, then low one cycle, so every edge is seen
    always @(posedge i_clk) begin
        if (i_start && !o_busy) begin
            left_r <= {i_n_pulses, 1'b0};
        end else if (o_busy) begin
            o_dig <= {8{~left_r[0]}};
            left_r <= left_r - 17'h00001;
        end
    end
endmodule

// *** iocdm_top_tb.sv ***
// Self-checking bench for the channel monitor
`timescale 1ns/100ps
module iocdm_top_tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_sup_short = 1'b0, i_sup_det_en = 1'b1;
    logic i_over_en = 1'b1, i_under_en = 1'b1, start = 1'b0, busy, restore_done, sup_err;
    // Clear held through the first restore: retained store starts unknown
    logic [7:0] dig, i_cnt_err_en = 8'h05, i_cnt_clr = 8'hff, i_avg_mode = 8'h00, o_cnt_err;
    logic [127:0] i_cnt_thr = {{7{16'hffff}}, 16'h0001};
    logic [215:0] o_cnt_value;
    logic [63:0] i_ai_sample = 64'h0, i_ulim_hi = 64'h0, i_ulim_lo = 64'h0, o_ai_data;
    logic [3:0] i_ai_valid = 4'h0, i_ulim_hi_en = 4'h0, i_ulim_lo_en = 4'h0, o_ai_upd;
    logic [3:0] o_over_err, o_under_err, o_ulim_hi_err, o_ulim_lo_err;
    logic [11:0] i_ai_range = 12'h000;
    logic [1:0] i_fmt = 2'h0;
    logic [15:0] n_pulses = 16'h0000;
    logic [19:0] exp_q[$], exp_e;
    int err_total = 0, num_checks = 0, cyc = 0, r, k;
    int hist[8], lo, hi, m, avg, fmt, uh, ul;
    bit oven, unen, uhe, ule;
    int LO[8] = '{-1000, -500, -2000, 0, 0, 100, 0, 400};
    int HI[8] = '{1000, 500, 2000, 1000, 500, 500, 2000, 2000};
    int MG[8] = '{10, 5, 20, 5, 2, 2, 10, 8};

    iocdm_top #(.HOUR_CYCLES(64'h0000000000000032)) u_iocdm_top (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dig_in(dig), .i_cnt_err_en(i_cnt_err_en),
        .i_cnt_thr(i_cnt_thr), .i_cnt_clr(i_cnt_clr), .o_cnt_err(o_cnt_err),
        .o_cnt_value(o_cnt_value), .o_restore_done(restore_done),
        .i_sup_short(i_sup_short), .i_sup_det_en(i_sup_det_en), .o_sup_err(sup_err),
        .i_ai_sample(i_ai_sample), .i_ai_valid(i_ai_valid), .i_ai_range(i_ai_range),
        .i_avg_mode(i_avg_mode), .i_fmt(i_fmt), .i_over_en(i_over_en),
        .i_under_en(i_under_en), .i_ulim_hi_en(i_ulim_hi_en), .i_ulim_lo_en(i_ulim_lo_en),
        .i_ulim_hi(i_ulim_hi), .i_ulim_lo(i_ulim_lo), .o_ai_data(o_ai_data),
        .o_ai_upd(o_ai_upd), .o_over_err(o_over_err), .o_under_err(o_under_err),
        .o_ulim_hi_err(o_ulim_hi_err), .o_ulim_lo_err(o_ulim_lo_err));

    iocdm_field_model u_iocdm_field_model (
        .i_clk(i_clk), .i_start(start), .i_n_pulses(n_pulses), .o_dig(dig), .o_busy(busy));

    always #12.5 i_clk = ~i_clk;

    task automatic chk(input logic [223:0] got, input logic [223:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset;
        int w;
        i_rst_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        w = 0;
        do begin
            @(posedge i_clk);
            w++;
        end while (restore_done !== 1'b1 && w < 50);
        chk(restore_done, 1'b1);
    endtask

    task automatic pulse(input int n);
        int w;
        n_pulses <= n[15:0];
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        w = 0;
        do begin
            @(posedge i_clk);
            w++;
        end while (busy && w < 70000);
        repeat (6) @(posedge i_clk);
    endtask

    // Note the expected report, then strobe the sample in
    task automatic ai_send(input int s);
        int j, sum, a;
        logic [15:0] d;
        for (j = 7; j > 0; j--) hist[j] = hist[j-1];
        hist[0] = s;
        sum = 0;
        for (j = 0; j < (1 << avg); j++) sum += hist[j];
        a = sum >>> avg;
        d = a[15:0];
        if (fmt == 0) d[15] = ~d[15];
        else if (fmt == 1 && a < 0) d = {1'b1, 15'(-a)};
        exp_q.push_back({d, oven && a > hi + m, unen && a < lo - m, uhe && a > uh, ule && a < ul});
        i_ai_sample <= {4{s[15:0]}};
        i_ai_valid <= 4'hf;
        @(posedge i_clk);
    endtask

    // All four channels share one setting, so each must match the same note
    always @(negedge i_clk) begin
        if (o_ai_upd[0] === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b1, 1'b0);
            end else begin
                exp_e = exp_q.pop_front();
                for (int c = 0; c < 4; c++) begin
                    chk({o_ai_upd[c], o_ai_data[c*16 +: 16], o_over_err[c], o_under_err[c],
                         o_ulim_hi_err[c], o_ulim_lo_err[c]}, {1'b1, exp_e});
                end
            end
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(68442));
        do_reset();
        i_cnt_clr <= 8'hff;
        @(posedge i_clk);
        i_cnt_clr <= 8'h00;
        repeat (2) @(posedge i_clk);
        chk(o_cnt_value, 216'h0);
        pulse(1000);
        chk({o_cnt_value, o_cnt_err}, {{8{27'h00003e8}}, 8'h00});
        pulse(1);
        chk({o_cnt_value, o_cnt_err}, {{8{27'h00003e9}}, 8'h01});
        repeat (130) @(posedge i_clk);
        do_reset();
        repeat (2) @(posedge i_clk);
        chk({o_cnt_value, o_cnt_err}, {{8{27'h00003e9}}, 8'h01});
        i_cnt_clr <= 8'h01;
        @(posedge i_clk);
        i_cnt_clr <= 8'h00;
        repeat (3) @(posedge i_clk);
        chk({o_cnt_value, o_cnt_err}, {{7{27'h00003e9}}, 27'h0, 8'h00});
        for (k = 0; k < 4; k++) begin
            i_sup_det_en <= k[1];
            i_sup_short <= k[0];
            repeat (5) @(posedge i_clk);
            chk(sup_err, k[1] & k[0]);
        end
        foreach (hist[j]) hist[j] = 0;
        for (r = 0; r < 8; r++) begin
            lo = LO[r];
            hi = HI[r];
            m = MG[r];
            avg = r >> 1;
            fmt = r & 3;
            oven = (r != 3);
            unen = (r != 4);
            uhe = (r != 1);
            ule = (r != 2);
            uh = lo + 10 + $urandom % (hi - lo - 20);
            ul = lo + 10 + $urandom % (hi - lo - 20);
            i_ai_range <= {4{r[2:0]}};
            i_avg_mode <= {4{avg[1:0]}};
            i_fmt <= fmt[1:0];
            i_over_en <= oven;
            i_under_en <= unen;
            i_ulim_hi_en <= {4{uhe}};
            i_ulim_lo_en <= {4{ule}};
            i_ulim_hi <= {4{uh[15:0]}};
            i_ulim_lo <= {4{ul[15:0]}};
            repeat (3) @(posedge i_clk);
            repeat (12) ai_send(lo - 40 + $urandom % (hi - lo + 81));
            i_ai_valid <= 4'h0;
            repeat (4) @(posedge i_clk);
        end
        chk(exp_q.size(), 0);
        print_verdict();
    end
endmodule
